// ===== rtl/cma_pkg.sv
package cma_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned EVT_W  = 3;

	// Register offsets
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_MASK   = 4'h1;
	localparam logic [3:0] OFF_STATUS = 4'h2;
	localparam logic [3:0] OFF_LIVE   = 4'h3;

	// Control field positions
	localparam int unsigned CTRL_IRQ_PIN_SELECT = 0;
	localparam int unsigned CTRL_IN1_ALARM_EN   = 1;
	localparam int unsigned CTRL_IN2_ALARM_EN   = 2;
	localparam int unsigned CTRL_IRQ_POLARITY   = 3;
	localparam int unsigned CTRL_ALARM_POLARITY = 4;
	localparam int unsigned CTRL_OUT_RELEASE    = 5;
	localparam logic [7:0]  CTRL_USED           = 8'h3F;

	// Event positions in status and mask
	localparam int unsigned EVT_LOSS_ONE  = 0;
	localparam int unsigned EVT_LOSS_TWO  = 1;
	localparam int unsigned EVT_RATE_RSVD = 2;

	// Live status positions
	localparam int unsigned LIVE_LOSS_ONE = 0;
	localparam int unsigned LIVE_LOSS_TWO = 1;
	localparam int unsigned LIVE_REF_XTAL = 2;
	localparam int unsigned LIVE_OUT_ON   = 3;

	// Reference rate pin levels
	localparam logic [1:0] RATE_LOW  = 2'h0;
	localparam logic [1:0] RATE_MID  = 2'h1;
	localparam logic [1:0] RATE_HIGH = 2'h2;

	// Values after reset
	localparam logic [7:0] CTRL_RESET   = 8'h10;
	localparam logic [2:0] MASK_RESET   = 3'h0;
	localparam logic [2:0] STATUS_RESET = 3'h0;
	localparam logic [7:0] RDATA_RESET  = 8'h00;
	localparam logic       REF_RESET    = 1'b1;
endpackage

// ===== rtl/cma_pin_drv.sv
`timescale 1ns/1ps
module cma_pin_drv (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// Function
	input  wire logic enable,
	input  wire logic native,
	input  wire logic active_high,
	// Pin
	output logic      pin_o,
	output logic      pin_oe_n
);
	logic pin_d;
	logic oe_n_d;

	// Native level is inverted when the function is programmed active low
	always_comb begin
		pin_d  = active_high ? native : ~native;
		oe_n_d = ~enable;
		if (!enable) begin
			pin_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_o    <= 1'b0;
			pin_oe_n <= 1'b1;
		end else if (ce) begin
			pin_o    <= pin_d;
			pin_oe_n <= oe_n_d;
		end
	end
endmodule // cma_pin_drv

// ===== rtl/cma_event_reg.sv
`timescale 1ns/1ps
module cma_event_reg (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        ce,
	// Events and software access
	input  wire logic [cma_pkg::EVT_W-1:0]   set,
	input  wire logic                        clr_we,
	input  wire logic                        mask_we,
	input  wire logic [cma_pkg::EVT_W-1:0]   wdata,
	// State
	output logic      [cma_pkg::EVT_W-1:0]   status_q,
	output logic      [cma_pkg::EVT_W-1:0]   mask_q,
	output logic                             pending
);
	logic [cma_pkg::EVT_W-1:0] status_d;
	logic [cma_pkg::EVT_W-1:0] mask_d;

	// Set wins over a write-one clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < cma_pkg::EVT_W; i++) begin : g_bit
			always_comb begin
				status_d[i] = set[i] | (status_q[i] & ~(clr_we & wdata[i]));
			end
		end
	endgenerate

	always_comb begin
		mask_d = mask_we ? wdata : mask_q;
	end

	assign pending = |(status_q & mask_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= cma_pkg::STATUS_RESET;
			mask_q   <= cma_pkg::MASK_RESET;
		end else if (ce) begin
			status_q <= status_d;
			mask_q   <= mask_d;
		end
	end
endmodule // cma_event_reg

// ===== rtl/cma_alarm_top.sv
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Reset returns every flip-flop and every configuration register to its default.
// - Both clock output pairs stay tristated while reset is in effect.
// - With interrupt select set the shared pin is the masked interrupt at its polarity.
// - With input-1 alarm enable set and interrupt select clear it shows input-1 loss.
// - The shared alarm uses the common alarm polarity and tristates if nothing is chosen.
// - With input-2 alarm enable set the second pin shows input-2 loss, 1 for loss when the alarm polarity is active high.
// - The second pin uses the common alarm polarity and tristates when not enabled.
// - The rate pin picks crystal on low, external clock on mid, and high is reserved.
module cma_alarm_top (
	// Clock, reset, enable
	input  wire logic                        MCLK,
	input  wire logic                        RST,
	input  wire logic                        CE,
	// Register port
	input  wire logic [cma_pkg::ADDR_W-1:0]  ADDR,
	input  wire logic [cma_pkg::DATA_W-1:0]  WDATA,
	input  wire logic                        WE,
	input  wire logic                        RE,
	output logic      [cma_pkg::DATA_W-1:0]  RDATA,
	// Monitor and strap inputs
	input  wire logic                        SIGNAL_LOSS_ONE,
	input  wire logic                        SIGNAL_LOSS_TWO,
	input  wire logic [1:0]                  RATE_LEVEL,
	// Alarm pins
	output logic                             IRQ_OR_IN1_ALARM_PIN_O,
	output logic                             IRQ_OR_IN1_ALARM_PIN_OE_N,
	output logic                             IN2_ALARM_PIN_O,
	output logic                             IN2_ALARM_PIN_OE_N,
	// Clock output enables and reference select
	output logic                             CKOUT1_OE_N,
	output logic                             CKOUT2_OE_N,
	output logic                             REF_IS_CRYSTAL,
	// Interrupt
	output logic                             IRQ
);
	logic [7:0]                ctrl_q;
	logic [7:0]                ctrl_d;
	logic [cma_pkg::EVT_W-1:0] status_q;
	logic [cma_pkg::EVT_W-1:0] mask_q;
	logic [cma_pkg::EVT_W-1:0] evt_set;
	logic                      pending;
	logic                      loss1_q;
	logic                      loss1_d;
	logic                      loss2_q;
	logic                      loss2_d;
	logic                      ref_q;
	logic                      ref_d;
	logic                      irq_d;
	logic                      ck_oe_n_d;
	logic [7:0]                rdata_d;
	logic [7:0]                live;
	logic                      wr_ctrl;
	logic                      wr_mask;
	logic                      wr_status;
	logic                      irq_sel;
	logic                      in1_en;
	logic                      in2_en;
	logic                      shared_en;
	logic                      shared_native;
	logic                      shared_pol;

	assign wr_ctrl   = WE && (ADDR == cma_pkg::OFF_CTRL);
	assign wr_mask   = WE && (ADDR == cma_pkg::OFF_MASK);
	assign wr_status = WE && (ADDR == cma_pkg::OFF_STATUS);

	assign irq_sel = ctrl_q[cma_pkg::CTRL_IRQ_PIN_SELECT];
	assign in1_en  = ctrl_q[cma_pkg::CTRL_IN1_ALARM_EN];
	assign in2_en  = ctrl_q[cma_pkg::CTRL_IN2_ALARM_EN];

	// Control register and input history
	always_comb begin
		ctrl_d  = ctrl_q;
		loss1_d = SIGNAL_LOSS_ONE;
		loss2_d = SIGNAL_LOSS_TWO;
		ref_d   = ref_q;
		if (wr_ctrl) begin
			ctrl_d = WDATA & cma_pkg::CTRL_USED;
		end
		case (RATE_LEVEL)
			cma_pkg::RATE_LOW: begin
				ref_d = 1'b1;
			end
			cma_pkg::RATE_MID: begin
				ref_d = 1'b0;
			end
			default: begin
				// Reserved level keeps the last valid choice
				ref_d = ref_q;
			end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_q  <= cma_pkg::CTRL_RESET;
			loss1_q <= 1'b0;
			loss2_q <= 1'b0;
			ref_q   <= cma_pkg::REF_RESET;
		end else if (CE) begin
			ctrl_q  <= ctrl_d;
			loss1_q <= loss1_d;
			loss2_q <= loss2_d;
			ref_q   <= ref_d;
		end
	end

	// Rising loss edges and reserved rate level raise events
	always_comb begin
		evt_set                         = '0;
		evt_set[cma_pkg::EVT_LOSS_ONE]  = SIGNAL_LOSS_ONE & ~loss1_q;
		evt_set[cma_pkg::EVT_LOSS_TWO]  = SIGNAL_LOSS_TWO & ~loss2_q;
		evt_set[cma_pkg::EVT_RATE_RSVD] = (RATE_LEVEL != cma_pkg::RATE_LOW) &&
		                                  (RATE_LEVEL != cma_pkg::RATE_MID);
	end

	cma_event_reg u_events (
		.clk      (MCLK),
		.rst      (RST),
		.ce       (CE),
		.set      (evt_set),
		.clr_we   (wr_status),
		.mask_we  (wr_mask),
		.wdata    (WDATA[cma_pkg::EVT_W-1:0]),
		.status_q (status_q),
		.mask_q   (mask_q),
		.pending  (pending)
	);

	// Shared pin: interrupt has precedence over the input-1 alarm
	always_comb begin
		shared_en     = irq_sel | in1_en;
		shared_native = SIGNAL_LOSS_ONE;
		shared_pol    = ctrl_q[cma_pkg::CTRL_ALARM_POLARITY];
		if (irq_sel) begin
			shared_native = pending;
			shared_pol    = ctrl_q[cma_pkg::CTRL_IRQ_POLARITY];
		end
	end

	cma_pin_drv u_shared_pin (
		.clk         (MCLK),
		.rst         (RST),
		.ce          (CE),
		.enable      (shared_en),
		.native      (shared_native),
		.active_high (shared_pol),
		.pin_o       (IRQ_OR_IN1_ALARM_PIN_O),
		.pin_oe_n    (IRQ_OR_IN1_ALARM_PIN_OE_N)
	);

	cma_pin_drv u_in2_pin (
		.clk         (MCLK),
		.rst         (RST),
		.ce          (CE),
		.enable      (in2_en),
		.native      (SIGNAL_LOSS_TWO),
		.active_high (ctrl_q[cma_pkg::CTRL_ALARM_POLARITY]),
		.pin_o       (IN2_ALARM_PIN_O),
		.pin_oe_n    (IN2_ALARM_PIN_OE_N)
	);

	// Live view of block state
	always_comb begin
		live                         = '0;
		live[cma_pkg::LIVE_LOSS_ONE] = loss1_q;
		live[cma_pkg::LIVE_LOSS_TWO] = loss2_q;
		live[cma_pkg::LIVE_REF_XTAL] = ref_q;
		live[cma_pkg::LIVE_OUT_ON]   = ~CKOUT1_OE_N;
	end

	// Outputs and read data
	always_comb begin
		irq_d     = pending;
		// Clocks stay off until software releases them after programming
		ck_oe_n_d = ~ctrl_q[cma_pkg::CTRL_OUT_RELEASE];
		rdata_d   = RDATA;
		if (RE) begin
			case (ADDR)
				cma_pkg::OFF_CTRL: begin
					rdata_d = ctrl_q;
				end
				cma_pkg::OFF_MASK: begin
					rdata_d = {5'h0, mask_q};
				end
				cma_pkg::OFF_STATUS: begin
					rdata_d = {5'h0, status_q};
				end
				cma_pkg::OFF_LIVE: begin
					rdata_d = live;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			IRQ            <= 1'b0;
			CKOUT1_OE_N    <= 1'b1;
			CKOUT2_OE_N    <= 1'b1;
			REF_IS_CRYSTAL <= cma_pkg::REF_RESET;
			RDATA          <= cma_pkg::RDATA_RESET;
		end else if (CE) begin
			IRQ            <= irq_d;
			CKOUT1_OE_N    <= ck_oe_n_d;
			CKOUT2_OE_N    <= ck_oe_n_d;
			REF_IS_CRYSTAL <= ref_d;
			RDATA          <= rdata_d;
		end
	end
endmodule // cma_alarm_top

// ===== test/cma_host_model.sv
`timescale 1ns/1ps
module cma_host_model (
	// Device side
	input  wire logic clk,
	input  wire logic o,
	input  wire logic oe_n,
	// Board side
	output logic      level
);
	logic last_q, last_d;
	always_comb last_d = oe_n ? last_q : o;
	always_ff @(posedge clk) last_q <= last_d;
	// No pull on the line: a released pin shows the inverse of its last value
	assign level = oe_n ? ~last_q : o;
endmodule // cma_host_model

// ===== test/cma_alarm_assertions.sv
`timescale 1ns/1ps
module cma_alarm_checker (
	// Clock and reset
	input wire logic       MCLK,
	input wire logic       RST,
	input wire logic       CE,
	// Register writes and monitors
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WE,
	input wire logic       SIGNAL_LOSS_ONE,
	input wire logic       SIGNAL_LOSS_TWO,
	input wire logic [1:0] RATE_LEVEL,
	// Outputs
	input wire logic [7:0] RDATA,
	input wire logic       IRQ_OR_IN1_ALARM_PIN_O,
	input wire logic       IRQ_OR_IN1_ALARM_PIN_OE_N,
	input wire logic       IN2_ALARM_PIN_O,
	input wire logic       IN2_ALARM_PIN_OE_N,
	input wire logic       CKOUT1_OE_N,
	input wire logic       CKOUT2_OE_N,
	input wire logic       REF_IS_CRYSTAL,
	input wire logic       IRQ
);
	logic [7:0] c_q, c_d;
	logic       m_q, m_d, ce_q;
	always_comb begin
		c_d = c_q;
		m_d = m_q;
		if (CE && WE && ADDR == cma_pkg::OFF_CTRL) c_d = WDATA & cma_pkg::CTRL_USED;
		if (CE && WE && ADDR == cma_pkg::OFF_MASK) m_d = WDATA[0];
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			c_q <= cma_pkg::CTRL_RESET;
			m_q <= 1'b0;
			ce_q <= 1'b0;
		end else begin
			c_q <= c_d;
			m_q <= m_d;
			ce_q <= CE;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST || !CE || !ce_q);
	sequence s_loss_rise;
		$rose(SIGNAL_LOSS_ONE) && m_q;
	endsequence
	a_reset_hiz: assert property (@(posedge MCLK) disable iff (1'b0)
		RST |-> CKOUT1_OE_N && CKOUT2_OE_N && IRQ_OR_IN1_ALARM_PIN_OE_N
		&& IN2_ALARM_PIN_OE_N && !IRQ && RDATA == 8'h00) else $error("pins driven in reset");
	a_clock_gate: assert property (
		CKOUT1_OE_N == !$past(c_q[5]) && CKOUT2_OE_N == CKOUT1_OE_N) else $error("clock gate");
	a_in2_alarm: assert property ($past(c_q[2]) |-> !IN2_ALARM_PIN_OE_N
		&& IN2_ALARM_PIN_O == ($past(SIGNAL_LOSS_TWO) ~^ $past(c_q[4]))) else $error("in2 pin");
	a_in2_hiz: assert property (
		!$past(c_q[2]) |-> IN2_ALARM_PIN_OE_N) else $error("in2 not released");
	a_shared_alarm: assert property ($past(c_q[1:0]) == 2'b10
		|-> !IRQ_OR_IN1_ALARM_PIN_OE_N && IRQ_OR_IN1_ALARM_PIN_O ==
		($past(SIGNAL_LOSS_ONE) ~^ $past(c_q[4]))) else $error("shared alarm");
	a_shared_hiz: assert property (
		$past(c_q[1:0]) == 2'b00 |-> IRQ_OR_IN1_ALARM_PIN_OE_N) else $error("shared not off");
	a_shared_irq: assert property ($past(c_q[0]) |-> !IRQ_OR_IN1_ALARM_PIN_OE_N
		&& IRQ_OR_IN1_ALARM_PIN_O == (IRQ ~^ $past(c_q[3]))) else $error("shared irq");
	a_irq_event: assert property (
		s_loss_rise |-> ##[1:3] IRQ) else $error("irq missing");
	a_ref_select: assert property (REF_IS_CRYSTAL == ($past(RATE_LEVEL[1]) ?
		$past(REF_IS_CRYSTAL) : $past(RATE_LEVEL) == cma_pkg::RATE_LOW)) else $error("ref");
endmodule // cma_alarm_checker
bind cma_alarm_top cma_alarm_checker i_cma_alarm_checker (.*);

// ===== test/cma_alarm_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module cma_alarm_top_test;
	logic       mclk, rst, ce, we, re, loss1, loss2, sp, rv;
	logic       sh_o, sh_n, in2_o, in2_n, ck1, ck2, refx, irq, sh_w, in2_w;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, c, exp_v;
	logic [1:0] rate, lv;
	logic [7:0] q[$];
	int         n_errors, total_checks, cyc;
	cma_alarm_top i_cma_alarm_top (.MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WE(we), .RE(re), .RDATA(rdata), .SIGNAL_LOSS_ONE(loss1),
		.SIGNAL_LOSS_TWO(loss2), .RATE_LEVEL(rate), .IRQ_OR_IN1_ALARM_PIN_O(sh_o),
		.IRQ_OR_IN1_ALARM_PIN_OE_N(sh_n), .IN2_ALARM_PIN_O(in2_o), .IN2_ALARM_PIN_OE_N(in2_n),
		.CKOUT1_OE_N(ck1), .CKOUT2_OE_N(ck2), .REF_IS_CRYSTAL(refx), .IRQ(irq));
	cma_host_model i_cma_host_model (.clk(mclk), .o(sh_o), .oe_n(sh_n), .level(sh_w));
	cma_host_model i_cma_host_model_2 (.clk(mclk), .o(in2_o), .oe_n(in2_n), .level(in2_w));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [7:0] pv(logic [7:0] k, logic l1, logic l2, logic p, logic f);
		return {p, f, !k[5], !k[5], !k[2], k[2] & (l2 ~^ k[4]), !(k[0] | k[1]),
			k[0] ? (p ~^ k[3]) : k[1] & (l1 ~^ k[4])};
	endfunction
	task automatic final_report();
		// Expectations that never met a result count as mismatches
		n_errors += q.size();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Compares the oldest expectation with a read result or a pin snapshot
	always @(posedge mclk) begin
		if (rv || sp) begin
			// Take the note once, so a mismatch cannot pop a second one
			exp_v = q.pop_front();
			`CHK(rv ? rdata : {irq, refx, ck2, ck1, in2_n, !in2_n & in2_w, sh_n,
				!sh_n & sh_w}, exp_v)
		end
		rv <= re;
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge mclk);
		we <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		re <= 1'b1;
		q.push_back(e);
		@(posedge mclk);
		re <= 1'b0;
	endtask
	task automatic pins(logic [7:0] e);
		repeat (2) @(posedge mclk);
		sp <= 1'b1;
		q.push_back(e);
		@(posedge mclk);
		sp <= 1'b0;
	endtask
	initial begin
		// Scheduled so the asynchronous reset sees a clean rising edge
		rst <= 1'b1;
		ce <= 1'b1;
		{we, re, loss1, loss2, sp} <= 5'h00;
		addr <= 4'h0;
		wdata <= 8'h00;
		rate <= cma_pkg::RATE_LOW;
		void'($urandom(42430));
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd(cma_pkg::OFF_CTRL, cma_pkg::CTRL_RESET);
		rd(cma_pkg::OFF_MASK, 8'h00);
		rd(4'hF, 8'h00);
		pins(pv(cma_pkg::CTRL_RESET, 1'b0, 1'b0, 1'b0, 1'b1));
		wr(cma_pkg::OFF_CTRL, 8'hFF);
		rd(cma_pkg::OFF_CTRL, 8'h3F);
		// Mask stays clear, so with interrupt select set the shared pin shows only its inactive interrupt level
		for (int i = 0; i < 24; i++) begin
			c = 8'($urandom);
			lv = 2'($urandom);
			wr(cma_pkg::OFF_CTRL, c);
			loss1 <= lv[0];
			loss2 <= lv[1];
			pins(pv(c & 8'h3F, lv[0], lv[1], 1'b0, 1'b1));
		end
		loss1 <= 1'b0;
		wr(cma_pkg::OFF_CTRL, 8'h21);
		wr(cma_pkg::OFF_STATUS, 8'h07);
		wr(cma_pkg::OFF_MASK, 8'h01);
		rd(cma_pkg::OFF_STATUS, 8'h00);
		loss1 <= 1'b1;
		pins(pv(8'h21, 1'b1, 1'b0, 1'b1, 1'b1));
		rd(cma_pkg::OFF_STATUS, 8'h01);
		rd(cma_pkg::OFF_LIVE, {4'h0, 2'b11, lv[1], 1'b1});
		wr(cma_pkg::OFF_MASK, 8'h00);
		pins(pv(8'h21, 1'b1, 1'b0, 1'b0, 1'b1));
		wr(cma_pkg::OFF_MASK, 8'h01);
		wr(cma_pkg::OFF_CTRL, 8'h2B);
		pins(pv(8'h2B, 1'b1, 1'b0, 1'b1, 1'b1));
		wr(cma_pkg::OFF_STATUS, 8'h01);
		pins(pv(8'h2B, 1'b1, 1'b0, 1'b0, 1'b1));
		rate <= cma_pkg::RATE_MID;
		pins(pv(8'h2B, 1'b1, 1'b0, 1'b0, 1'b0));
		rate <= cma_pkg::RATE_HIGH;
		pins(pv(8'h2B, 1'b1, 1'b0, 1'b0, 1'b0));
		rd(cma_pkg::OFF_STATUS, 8'h04);
		rate <= cma_pkg::RATE_LOW;
		pins(pv(8'h2B, 1'b1, 1'b0, 1'b0, 1'b1));
		// A write while the clock enable is low must be lost
		ce <= 1'b0;
		wr(cma_pkg::OFF_CTRL, 8'h00);
		ce <= 1'b1;
		rd(cma_pkg::OFF_CTRL, 8'h2B);
		pins(pv(8'h2B, 1'b1, 1'b0, 1'b0, 1'b1));
		rst <= 1'b1;
		pins(pv(cma_pkg::CTRL_RESET, 1'b0, 1'b0, 1'b0, 1'b1));
		rst <= 1'b0;
		rd(cma_pkg::OFF_CTRL, cma_pkg::CTRL_RESET);
		// Let the last read data be compared before the verdict
		repeat (2) @(posedge mclk);
		final_report();
	end
endmodule // cma_alarm_top_test
